// ==== dv/lpbf_monitor.sv ====
// Checker for the octet stream that the station end sends to the peer end.
// Assumes one clock and the asynchronous active-low reset of both ends.
`default_nettype none
module lpbf_monitor (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic       d2p_valid,
	input wire logic [7:0] d2p_data,
	input wire logic       d2p_last,
	input wire logic       d2p_ready
);
	logic [3:0] ix_r;
	logic [7:0] b0_r;
	logic [7:0] b1_r;
	wire logic tk = d2p_valid && d2p_ready;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Octet index within the unit, pinned at 8 once into the payload.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) ix_r <= 4'h0;
		else if (tk) ix_r <= d2p_last ? 4'h0 : (ix_r == 4'h8 ? ix_r : ix_r + 4'h1);
	end
	always_ff @(posedge core_clk_in) begin
		if (tk && ix_r == 4'h0) b0_r <= d2p_data;
		if (tk && ix_r == 4'h1) b1_r <= d2p_data;
	end
	a_hold_offer: assert property (d2p_valid && !d2p_ready |=> d2p_valid && $stable(d2p_data))
		else $error("offered octet changed before it was taken");
	a_svc_code: assert property (d2p_valid && ix_r == 4'h0 |->
		d2p_data[3:0] == 4'h0 && d2p_data[7:4] inside {4'h3, 4'h4, 4'h5}) else $error("bad service");
	a_sub_code: assert property (d2p_valid && ix_r == 4'h1 |->
		d2p_data[3:0] == 4'h0 && d2p_data[7:4] inside {4'h1, 4'h4, 4'h8}) else $error("bad subtype");
	a_poll_retry: assert property (d2p_valid && ix_r == 4'h2 && b1_r[7:4] == 4'h4 |->
		d2p_data[7:4] == 4'h0) else $error("poll status high bits set");
	a_reply_code: assert property (d2p_valid && ix_r == 4'h2 && b1_r[7:4] == 4'h8 |->
		d2p_data != 8'h01) else $error("reserved reply status sent");
	a_msq_status: assert property (d2p_valid && ix_r == 4'h2 && b0_r[7:4] == 4'h5 |->
		d2p_data == 8'h00) else $error("multicast sequenced status not zero");
	a_muc_sap: assert property (d2p_valid && ix_r inside {4'h4, 4'h5} &&
		b0_r[7:4] == 4'h4 |-> d2p_data == 8'h00) else $error("multicast access point not zero");
	a_empty_len: assert property (d2p_valid && ix_r inside {4'h6, 4'h7} &&
		b1_r[7:4] inside {4'h4, 4'h8} |-> d2p_data == 8'h00 && (ix_r != 4'h7 || d2p_last))
		else $error("poll or reply length");
	a_no_early_last: assert property (d2p_valid && ix_r < 4'h7 |-> !d2p_last)
		else $error("unit ended inside header");
endmodule // lpbf_monitor
`default_nettype wire

// ==== dv/tb_link_pdu_body_framer.sv ====
// Bench joining the station end and the peer end across the octet link.
// Assumes a 200 MHz clock and a millisecond shortened to 4 cycles.
`default_nettype none
module tb_link_pdu_body_framer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, rv = 0, qv = 0, pv = 0, rid = 0, db, pb, de, pe, dpr, cfg, tmo;
	logic prx, pdr, ppv, drx, ddr;
	logic [2:0] rk = 3'h5;
	logic [7:0] mx = 8'h0A, dst, dsq;
	logic [7:0] rs = '0, rq = '0, pd = '0, dom = 8'h01, sta = 8'h01, outs, nseq, psq, pst, ppd;
	logic [3:0] rtry;
	logic [15:0] rsap = '0, rl = '0, plen, dlen;
	logic [31:0] ba = '0, bb = '0, ipa, ipb, r = 32'h0001_6A3A;
	lpbf_pkg::lpbf_kind_t pk, dk;
	int n_mismatch = 0, tests_run = 0, nto = 0;
	logic [34:0] q[$], dq[$];
	logic [7:0] pq[$];
	lpbf_link_if lk ();
	lpbf_dev_end #(.MS_CYC(4)) i_lpbf_dev_end (.core_clk_in(clk), .rst_n_in(rst_n), .link(lk.dev),
		.req_valid_in(rv), .req_kind_in(lpbf_pkg::lpbf_kind_t'(rk)), .req_status_in(rs),
		.req_seq_in(rq), .req_sap_in(rsap), .req_len_in(rl), .req_busy_out(db), .req_err_out(de),
		.pay_valid_in(pv), .pay_data_in(pd), .pay_ready_out(dpr), .rx_unit_out(drx),
		.rx_drop_out(ddr), .rx_kind_out(dk), .rx_status_out(dst), .rx_seq_out(dsq),
		.rx_sap_out(), .rx_len_out(dlen), .rx_pay_valid_out(), .rx_pay_data_out(),
		.base_a_in(ba), .base_b_in(bb),
		.max_dom_in(mx), .max_sta_in(mx), .dom_in(dom), .sta_in(sta), .rid_in(rid),
		.ip_a_out(ipa), .ip_b_out(ipb), .cfg_err_out(cfg), .reply_wait_ms_in(16'h0002),
		.idle_limit_s_in(16'h0001), .reply_timeout_out(tmo), .link_idle_out(),
		.retry_cnt_out(rtry), .outstanding_out(outs), .next_seq_out(nseq));
	lpbf_peer_end i_lpbf_peer_end (.core_clk_in(clk), .rst_n_in(rst_n), .link(lk.peer),
		.req_valid_in(qv), .req_kind_in(lpbf_pkg::lpbf_kind_t'(rk)), .req_status_in(rs),
		.req_seq_in(rq), .req_sap_in(rsap), .req_len_in(rl), .req_busy_out(pb), .req_err_out(pe),
		.pay_valid_in(1'b0), .pay_data_in(pd), .pay_ready_out(), .rx_unit_out(prx),
		.rx_drop_out(pdr), .rx_kind_out(pk), .rx_status_out(pst), .rx_seq_out(psq),
		.rx_len_out(plen), .rx_pay_valid_out(ppv), .rx_pay_data_out(ppd));
	lpbf_monitor i_lpbf_monitor (.core_clk_in(clk), .rst_n_in(rst_n), .d2p_valid(lk.d2p_valid),
		.d2p_data(lk.d2p_data), .d2p_last(lk.d2p_last), .d2p_ready(lk.d2p_ready));
	always #2.5 clk = ~clk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Pushes n random payload octets, each held until the FIFO takes it.
	task automatic pay(input int n);
		for (int i = 0; i < n; i++) begin
			r = nx(r);
			pv <= 1'b1;
			pd <= r[7:0];
			pq.push_back(r[7:0]);
			do @(posedge clk); while (!dpr);
		end
		pv <= 1'b0;
	endtask
	// Issues one request at the station end (d=1) or the peer end (d=0).
	task automatic req(input logic d, input logic [2:0] k, input logic [7:0] s, input logic [15:0] l);
		logic [7:0] es;
		logic [34:0] e;
		r = nx(r);
		es = (k == 3'h0) ? (s & 8'h0F) : (k == 3'h1) ? s : (k == 3'h2) ? (s & 8'h8F) : 8'h00;
		{rk, rs, rq, rsap, rl} <= {k, s, r[7:0], r[23:8], l};
		if (d) rv <= 1'b1; else qv <= 1'b1;
		@(posedge clk);
		{rv, qv} <= 2'b00;
		@(negedge clk);
		chk(d ? de : pe, k == 3'h5 || (k == 3'h1 && s == 8'h01));
		e = {k, es, rq, (k < 3'h2) ? 16'h0000 : l};
		if (d && !de) q.push_back(e);
		if (!d && !pe) dq.push_back(e);
		do @(posedge clk); while (d ? db : pb);
	endtask
	always @(posedge clk) begin
		nto += tmo;
		if (prx) chk({pk, pst, psq, plen}, q.pop_front());
		if (ppv) chk(ppd, pq.pop_front());
		if (pdr) chk(1'b1, 1'b0);
		if (drx) chk({dk, dst, dsq, dlen}, dq.pop_front());
		if (ddr) chk(1'b1, 1'b0);
	end
	initial begin
		#20us;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		{ba, bb} <= {8'h0A, r[23:0], 8'h0B, r[31:8]} & 64'hFFFF_FF00_FFFF_FF00;
		dom <= 8'(r[2:0]) + 8'h01;
		sta <= 8'(r[5:3]) + 8'h01;
		rid <= r[9];
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({rtry, outs, nto[0]}, '0);
		chk(ipa, ba + dom + 2 * sta + rid);
		chk({cfg, ipb}, {1'b0, bb + dom + 2 * sta + rid});
		@(posedge clk);
		mx <= 8'h02;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(cfg, 1'b1);
		@(posedge clk);
		mx <= 8'h0A;
		pay(3);
		req(1'b1, 3'h2, 8'hFF, 16'h0003);
		pay(2);
		req(1'b1, 3'h2, 8'h05, 16'h0002);
		pay(4);
		req(1'b1, 3'h3, r[7:0], 16'h0004);
		pay(1);
		req(1'b1, 3'h4, 8'hFF, 16'h0001);
		req(1'b1, 3'h1, 8'h01, 16'h0000);
		req(1'b0, 3'h5, 8'h00, 16'h0000);
		req(1'b1, 3'h1, 8'h02, 16'h0005);
		repeat (12) @(posedge clk);
		chk({outs, nto[0]}, {8'h02, 1'b0});
		req(1'b1, 3'h0, 8'hF7, 16'h0009);
		repeat (40) @(posedge clk);
		chk({outs, rtry != 4'h0, nto != 0}, {8'h00, 2'b11});
		req(1'b0, 3'h1, 8'h00, 16'h0000);
		repeat (20) @(posedge clk);
		chk({nseq, rtry}, {rq, 4'h0});
		chk(q.size() + pq.size() + dq.size(), 0);
		report_and_stop();
	end
endmodule // tb_link_pdu_body_framer
`default_nettype wire

// ==== hw/lpbf_dev_end.sv ====
// Station end: payload FIFO, unit builder, unit parser, timers, counters and address derivation.
// Assumes local management drives the configuration inputs on the same clock.
`default_nettype none
module lpbf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem_r[rd_r];
	always_comb cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	always_ff @(posedge clk_in) begin
		if (push)
			mem_r[wr_r] <= in_data_in;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_r         <= '0;
			rd_r         <= '0;
			cnt_r        <= '0;
			in_ready_out <= 1'b1;
		end else begin
			wr_r         <= push ? AW'(wr_r + 1'b1) : wr_r;
			rd_r         <= pop ? AW'(rd_r + 1'b1) : rd_r;
			cnt_r        <= cnt_nxt;
			in_ready_out <= (cnt_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule // lpbf_fifo

module lpbf_dev_end #(
	parameter int unsigned MS_CYC = lpbf_pkg::MS_CYCLES
) (
	input  wire logic                core_clk_in,
	input  wire logic                rst_n_in,
	lpbf_link_if.dev                 link,
	input  wire logic                req_valid_in,
	input  wire lpbf_pkg::lpbf_kind_t req_kind_in,
	input  wire logic          [7:0] req_status_in,
	input  wire logic          [7:0] req_seq_in,
	input  wire logic         [15:0] req_sap_in,
	input  wire logic         [15:0] req_len_in,
	output logic                     req_busy_out,
	output logic                     req_err_out,
	input  wire logic                pay_valid_in,
	input  wire logic          [7:0] pay_data_in,
	output logic                     pay_ready_out,
	output logic                     rx_unit_out,
	output logic                     rx_drop_out,
	output lpbf_pkg::lpbf_kind_t     rx_kind_out,
	output logic               [7:0] rx_status_out,
	output logic               [7:0] rx_seq_out,
	output logic              [15:0] rx_sap_out,
	output logic              [15:0] rx_len_out,
	output logic                     rx_pay_valid_out,
	output logic               [7:0] rx_pay_data_out,
	input  wire logic         [31:0] base_a_in,
	input  wire logic         [31:0] base_b_in,
	input  wire logic          [7:0] max_dom_in,
	input  wire logic          [7:0] max_sta_in,
	input  wire logic          [7:0] dom_in,
	input  wire logic          [7:0] sta_in,
	input  wire logic                rid_in,
	output logic              [31:0] ip_a_out,
	output logic              [31:0] ip_b_out,
	output logic                     cfg_err_out,
	input  wire logic         [15:0] reply_wait_ms_in,
	input  wire logic         [15:0] idle_limit_s_in,
	output logic                     reply_timeout_out,
	output logic                     link_idle_out,
	output logic               [3:0] retry_cnt_out,
	output logic               [7:0] outstanding_out,
	output logic               [7:0] next_seq_out
);
	typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY} lpbf_tx_t;
	lpbf_tx_t             tx_st_r;
	lpbf_pkg::lpbf_kind_t kind_r, sent_kind_r, rkind_r;
	logic [7:0]  st_r, seq_r, data_r;
	logic [15:0] sap_r, len_r, pcnt_r;
	logic [2:0]  idx_r;
	logic        valid_r, last_r, can_load, f_valid, f_pop, sent;
	logic [7:0]  f_data;
	logic [7:0]  hdr_r [8];
	logic [3:0]  ridx_r;
	logic        rdrop_r, rready_r, rx_acc, rx_ok;
	logic [31:0] ms_pre_r;
	logic [15:0] sec_pre_r, rt_cnt_r, id_cnt_r;
	logic        ms_tick_r, s_tick_r, rt_act_r, id_act_r;

	function automatic logic [31:0] ip_of(input logic [31:0] base);
		// base + domain + 2 * station + node.
		return base + {24'h0, dom_in} + {23'h0, sta_in, 1'b0} + {31'h0, rid_in};
	endfunction

	assign link.d2p_valid = valid_r;
	assign link.d2p_data  = data_r;
	assign link.d2p_last  = last_r;
	assign link.p2d_ready = rready_r;
	assign can_load = !valid_r || link.d2p_ready;
	assign f_pop    = (tx_st_r == TX_PAY) && can_load && f_valid;
	assign sent     = valid_r && link.d2p_ready && last_r;
	assign rx_acc   = link.p2d_valid && rready_r;
	// incomplete or unknown units never reach the user.
	assign rx_ok    = rx_acc && link.p2d_last && !rdrop_r && (ridx_r >= lpbf_pkg::HDR_LAST);

	lpbf_fifo #(.WIDTH(lpbf_pkg::FIFO_WIDTH), .DEPTH(lpbf_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in        (core_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (pay_valid_in),
		.in_data_in    (pay_data_in),
		.in_ready_out  (pay_ready_out),
		.out_valid_out (f_valid),
		.out_data_out  (f_data),
		.out_ready_in  (f_pop)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_st_r <= TX_IDLE;
			kind_r <= lpbf_pkg::K_NONE;
			sent_kind_r <= lpbf_pkg::K_NONE;
			{st_r, seq_r, data_r, sap_r, len_r, pcnt_r, idx_r} <= '0;
			{valid_r, last_r, req_busy_out, req_err_out} <= '0;
		end else begin
			req_err_out <= 1'b0;
			if (can_load)
				valid_r <= 1'b0;
			case (tx_st_r)
				TX_IDLE: if (req_valid_in) begin
					if (lpbf_pkg::lpbf_req_ok(req_kind_in, req_status_in)) begin
						kind_r <= req_kind_in;
						st_r <= req_status_in;
						seq_r <= req_seq_in;
						sap_r <= req_sap_in;
						len_r <= lpbf_pkg::lpbf_body_len(req_kind_in, req_len_in);
						idx_r <= 3'h0;
						req_busy_out <= 1'b1;
						tx_st_r <= TX_HDR;
					end else begin
						req_err_out <= 1'b1;
					end
				end
				TX_HDR: if (can_load) begin
					// header octets built with reserved bits zero.
					data_r <= lpbf_pkg::lpbf_hdr_byte(kind_r, idx_r, st_r, seq_r, sap_r, len_r);
					valid_r <= 1'b1;
					last_r <= (idx_r == 3'h7) && (len_r == 16'h0000);
					idx_r <= 3'(idx_r + 1'b1);
					pcnt_r <= 16'h0000;
					sent_kind_r <= kind_r;
					if (idx_r == 3'h7) begin
						tx_st_r <= (len_r == 16'h0000) ? TX_IDLE : TX_PAY;
						req_busy_out <= (len_r != 16'h0000);
					end
				end
				TX_PAY: if (f_pop) begin
					data_r <= f_data;
					valid_r <= 1'b1;
					last_r <= (pcnt_r == 16'(len_r - 1'b1));
					pcnt_r <= 16'(pcnt_r + 1'b1);
					if (pcnt_r == 16'(len_r - 1'b1)) begin
						tx_st_r <= TX_IDLE;
						req_busy_out <= 1'b0;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ridx_r <= '0;
			rdrop_r <= 1'b0;
			rready_r <= 1'b0;
			rkind_r <= lpbf_pkg::K_NONE;
			rx_kind_out <= lpbf_pkg::K_NONE;
			{rx_unit_out, rx_drop_out, rx_status_out, rx_seq_out, rx_sap_out} <= '0;
			{rx_len_out, rx_pay_valid_out, rx_pay_data_out} <= '0;
		end else begin
			rready_r <= 1'b1;
			rx_unit_out <= 1'b0;
			rx_drop_out <= 1'b0;
			rx_pay_valid_out <= 1'b0;
			if (rx_acc) begin
				if (ridx_r != lpbf_pkg::HDR_LEN) begin
					hdr_r[ridx_r[2:0]] <= link.p2d_data;
					ridx_r <= 4'(ridx_r + 1'b1);
				end else if (!rdrop_r) begin
					rx_pay_valid_out <= 1'b1;
					rx_pay_data_out <= link.p2d_data;
				end
				// unknown service and subtype pairs are dropped.
				if (ridx_r == 4'h1) begin
					rkind_r <= lpbf_pkg::lpbf_decode(hdr_r[0], link.p2d_data);
					rdrop_r <= lpbf_pkg::lpbf_decode(hdr_r[0], link.p2d_data) == lpbf_pkg::K_NONE;
				end
				if (link.p2d_last) begin
					ridx_r <= 4'h0;
					rdrop_r <= 1'b0;
					rx_unit_out <= rx_ok;
					rx_drop_out <= !rx_ok;
					if (rx_ok) begin
						rx_kind_out <= rkind_r;
						rx_status_out <= lpbf_pkg::lpbf_status(rkind_r, hdr_r[2]);
						rx_seq_out <= hdr_r[3];
						rx_sap_out <= {hdr_r[4], hdr_r[5]};
						rx_len_out <= {hdr_r[6],
							(ridx_r == lpbf_pkg::HDR_LAST) ? link.p2d_data : hdr_r[7]};
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ms_pre_r <= '0;
			sec_pre_r <= '0;
			ms_tick_r <= 1'b0;
			s_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= (ms_pre_r == MS_CYC - 1);
			ms_pre_r <= (ms_pre_r == MS_CYC - 1) ? 32'h0000_0000 : ms_pre_r + 32'h0000_0001;
			s_tick_r <= 1'b0;
			if (ms_tick_r) begin
				s_tick_r <= (sec_pre_r == 16'(lpbf_pkg::MS_PER_S - 1'b1));
				sec_pre_r <= (sec_pre_r == 16'(lpbf_pkg::MS_PER_S - 1'b1)) ? 16'h0000 :
					16'(sec_pre_r + 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{rt_act_r, id_act_r, reply_timeout_out, link_idle_out} <= '0;
			{rt_cnt_r, id_cnt_r, retry_cnt_out, outstanding_out} <= '0;
			next_seq_out <= lpbf_pkg::ST_NORMAL;
		end else begin
			reply_timeout_out <= 1'b0;
			if (sent && sent_kind_r == lpbf_pkg::K_POLL) begin
				rt_act_r <= 1'b1;
				rt_cnt_r <= reply_wait_ms_in;
				outstanding_out <= 8'h00;
			end else if (rx_ok && rkind_r == lpbf_pkg::K_REPLY) begin
				rt_act_r <= 1'b0;
				retry_cnt_out <= 4'h0;
				next_seq_out <= hdr_r[3];
			end else if (rt_act_r && ms_tick_r) begin
				rt_cnt_r <= 16'(rt_cnt_r - 1'b1);
				if (rt_cnt_r <= 16'h0001) begin
					rt_act_r <= 1'b0;
					reply_timeout_out <= 1'b1;
					retry_cnt_out <= (retry_cnt_out == 4'hF) ? 4'hF : 4'(retry_cnt_out + 1'b1);
				end
			end
			if (sent && sent_kind_r == lpbf_pkg::K_SEQ_DATA && outstanding_out != 8'hFF)
				outstanding_out <= 8'(outstanding_out + 1'b1);
			if (rx_ok) begin
				id_act_r <= 1'b1;
				id_cnt_r <= 16'h0000;
			end else if (id_act_r && s_tick_r && id_cnt_r != 16'hFFFF) begin
				id_cnt_r <= 16'(id_cnt_r + 1'b1);
			end
			link_idle_out <= id_act_r && (id_cnt_r >= idle_limit_s_in);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ip_a_out <= '0;
			ip_b_out <= '0;
			cfg_err_out <= 1'b0;
		end else begin
			ip_a_out <= ip_of(base_a_in);
			ip_b_out <= ip_of(base_b_in);
			cfg_err_out <= (dom_in == 8'h00) || (dom_in > max_dom_in) ||
				(sta_in == 8'h00) || (sta_in > max_sta_in);
		end
	end
endmodule // lpbf_dev_end
`default_nettype wire

// ==== hw/lpbf_peer_end.sv ====
// Peer end: builds units toward the station and parses units from it.
// Assumes the same clock as the station end and the shared payload FIFO module.
`default_nettype none
module lpbf_peer_end (
	input  wire logic                core_clk_in,
	input  wire logic                rst_n_in,
	lpbf_link_if.peer                link,
	input  wire logic                req_valid_in,
	input  wire lpbf_pkg::lpbf_kind_t req_kind_in,
	input  wire logic          [7:0] req_status_in,
	input  wire logic          [7:0] req_seq_in,
	input  wire logic         [15:0] req_sap_in,
	input  wire logic         [15:0] req_len_in,
	output logic                     req_busy_out,
	output logic                     req_err_out,
	input  wire logic                pay_valid_in,
	input  wire logic          [7:0] pay_data_in,
	output logic                     pay_ready_out,
	output logic                     rx_unit_out,
	output logic                     rx_drop_out,
	output lpbf_pkg::lpbf_kind_t     rx_kind_out,
	output logic               [7:0] rx_status_out,
	output logic               [7:0] rx_seq_out,
	output logic              [15:0] rx_len_out,
	output logic                     rx_pay_valid_out,
	output logic               [7:0] rx_pay_data_out
);
	typedef enum logic [1:0] {PT_IDLE, PT_HDR, PT_PAY} lpbf_ptx_t;
	lpbf_ptx_t            st_r;
	lpbf_pkg::lpbf_kind_t kind_r, rkind_r;
	logic [7:0]  sts_r, seq_r, data_r, f_data;
	logic [15:0] sap_r, len_r, pcnt_r;
	logic [2:0]  idx_r;
	logic        valid_r, last_r, can_load, f_valid, f_pop;
	logic [7:0]  hdr_r [8];
	logic [3:0]  ridx_r;
	logic        rdrop_r, rready_r, rx_acc, rx_ok;

	assign link.p2d_valid = valid_r;
	assign link.p2d_data  = data_r;
	assign link.p2d_last  = last_r;
	assign link.d2p_ready = rready_r;
	assign can_load = !valid_r || link.p2d_ready;
	assign f_pop    = (st_r == PT_PAY) && can_load && f_valid;
	assign rx_acc   = link.d2p_valid && rready_r;
	assign rx_ok    = rx_acc && link.d2p_last && !rdrop_r && (ridx_r >= lpbf_pkg::HDR_LAST);

	lpbf_fifo #(.WIDTH(lpbf_pkg::FIFO_WIDTH), .DEPTH(lpbf_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in        (core_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (pay_valid_in),
		.in_data_in    (pay_data_in),
		.in_ready_out  (pay_ready_out),
		.out_valid_out (f_valid),
		.out_data_out  (f_data),
		.out_ready_in  (f_pop)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= PT_IDLE;
			kind_r <= lpbf_pkg::K_NONE;
			{sts_r, seq_r, data_r, sap_r, len_r, pcnt_r, idx_r} <= '0;
			{valid_r, last_r, req_busy_out, req_err_out} <= '0;
		end else begin
			req_err_out <= 1'b0;
			if (can_load)
				valid_r <= 1'b0;
			case (st_r)
				PT_IDLE: if (req_valid_in) begin
					if (lpbf_pkg::lpbf_req_ok(req_kind_in, req_status_in)) begin
						kind_r <= req_kind_in;
						sts_r <= req_status_in;
						seq_r <= req_seq_in;
						sap_r <= req_sap_in;
						len_r <= lpbf_pkg::lpbf_body_len(req_kind_in, req_len_in);
						idx_r <= 3'h0;
						req_busy_out <= 1'b1;
						st_r <= PT_HDR;
					end else begin
						req_err_out <= 1'b1;
					end
				end
				PT_HDR: if (can_load) begin
					// reply header built with zero length.
					data_r <= lpbf_pkg::lpbf_hdr_byte(kind_r, idx_r, sts_r, seq_r, sap_r, len_r);
					valid_r <= 1'b1;
					last_r <= (idx_r == 3'h7) && (len_r == 16'h0000);
					idx_r <= 3'(idx_r + 1'b1);
					pcnt_r <= 16'h0000;
					if (idx_r == 3'h7) begin
						st_r <= (len_r == 16'h0000) ? PT_IDLE : PT_PAY;
						req_busy_out <= (len_r != 16'h0000);
					end
				end
				PT_PAY: if (f_pop) begin
					data_r <= f_data;
					valid_r <= 1'b1;
					last_r <= (pcnt_r == 16'(len_r - 1'b1));
					pcnt_r <= 16'(pcnt_r + 1'b1);
					if (pcnt_r == 16'(len_r - 1'b1)) begin
						st_r <= PT_IDLE;
						req_busy_out <= 1'b0;
					end
				end
				default: st_r <= PT_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ridx_r <= '0;
			rdrop_r <= 1'b0;
			rready_r <= 1'b0;
			rkind_r <= lpbf_pkg::K_NONE;
			rx_kind_out <= lpbf_pkg::K_NONE;
			{rx_unit_out, rx_drop_out, rx_status_out, rx_seq_out, rx_len_out} <= '0;
			{rx_pay_valid_out, rx_pay_data_out} <= '0;
		end else begin
			rready_r <= 1'b1;
			rx_unit_out <= 1'b0;
			rx_drop_out <= 1'b0;
			rx_pay_valid_out <= 1'b0;
			if (rx_acc) begin
				if (ridx_r != lpbf_pkg::HDR_LEN) begin
					hdr_r[ridx_r[2:0]] <= link.d2p_data;
					ridx_r <= 4'(ridx_r + 1'b1);
				end else if (!rdrop_r) begin
					rx_pay_valid_out <= 1'b1;
					rx_pay_data_out <= link.d2p_data;
				end
				// reserved nibbles ignored in the kind check.
				if (ridx_r == 4'h1) begin
					rkind_r <= lpbf_pkg::lpbf_decode(hdr_r[0], link.d2p_data);
					rdrop_r <= lpbf_pkg::lpbf_decode(hdr_r[0], link.d2p_data) == lpbf_pkg::K_NONE;
				end
				if (link.d2p_last) begin
					ridx_r <= 4'h0;
					rdrop_r <= 1'b0;
					rx_unit_out <= rx_ok;
					rx_drop_out <= !rx_ok;
					if (rx_ok) begin
						rx_kind_out <= rkind_r;
						rx_status_out <= lpbf_pkg::lpbf_status(rkind_r, hdr_r[2]);
						rx_seq_out <= hdr_r[3];
						rx_len_out <= {hdr_r[6],
							(ridx_r == lpbf_pkg::HDR_LAST) ? link.d2p_data : hdr_r[7]};
					end
				end
			end
		end
	end
endmodule // lpbf_peer_end
`default_nettype wire

// ==== include/lpbf_link_if.sv ====
// Octet stream link between the station end and the peer end, one stream each way.
// Assumes both ends share one clock; valid and ready handshake with a last marker.
`default_nettype none
interface lpbf_link_if;
	logic       d2p_valid;
	logic [7:0] d2p_data;
	logic       d2p_last;
	logic       d2p_ready;
	logic       p2d_valid;
	logic [7:0] p2d_data;
	logic       p2d_last;
	logic       p2d_ready;
	modport dev (output d2p_valid, d2p_data, d2p_last, input d2p_ready,
		input p2d_valid, p2d_data, p2d_last, output p2d_ready);
	modport peer (input d2p_valid, d2p_data, d2p_last, output d2p_ready,
		output p2d_valid, p2d_data, p2d_last, input p2d_ready);
endinterface
`default_nettype wire

// ==== include/lpbf_pkg.sv ====
// Shared constants, unit kinds and header field helpers for the link unit body framer.
// Assumes both ends run on one clock and exchange whole units as octet streams.
`default_nettype none
package lpbf_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned SHORT_UNIT_MS = 1;
	localparam int unsigned LONG_UNIT_S   = 1;
	localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * SHORT_UNIT_MS;
	localparam logic [15:0] MS_PER_S      = 16'(1000 * LONG_UNIT_S);
	localparam int unsigned FIFO_WIDTH    = 8;
	localparam int unsigned FIFO_DEPTH    = 16;
	localparam logic [3:0]  SVC_SEQ       = 4'h3;
	localparam logic [3:0]  SVC_MUC       = 4'h4;
	localparam logic [3:0]  SVC_MSQ       = 4'h5;
	localparam logic [3:0]  SUB_DATA      = 4'h1;
	localparam logic [3:0]  SUB_POLL      = 4'h4;
	localparam logic [3:0]  SUB_REPLY     = 4'h8;
	localparam logic [7:0]  ST_NORMAL     = 8'h00;
	localparam logic [7:0]  ST_RESERVED   = 8'h01;
	localparam logic [7:0]  ST_BUSY       = 8'h02;
	localparam logic [7:0]  ST_SEQ_ERR    = 8'h03;
	localparam logic [2:0]  OFS_SVC       = 3'h0;
	localparam logic [2:0]  OFS_SUB       = 3'h1;
	localparam logic [2:0]  OFS_STATUS    = 3'h2;
	localparam logic [2:0]  OFS_SEQ       = 3'h3;
	localparam logic [2:0]  OFS_SAP_HI    = 3'h4;
	localparam logic [2:0]  OFS_SAP_LO    = 3'h5;
	localparam logic [2:0]  OFS_LEN_HI    = 3'h6;
	localparam logic [3:0]  HDR_LEN       = 4'h8;
	localparam logic [3:0]  HDR_LAST      = 4'h7;

	typedef enum logic [2:0] {
		K_POLL, K_REPLY, K_SEQ_DATA, K_MUC_DATA, K_MSQ_DATA, K_NONE
	} lpbf_kind_t;

	// Keeps only the defined status bits of each kind; the rest go out and come in as zero.
	function automatic logic [7:0] lpbf_status(input lpbf_kind_t k, input logic [7:0] st);
		case (k)
			K_POLL:     return {4'h0, st[3:0]};
			K_REPLY:    return st;
			K_SEQ_DATA: return {st[7], 3'b000, st[3:0]};
			default:    return 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] lpbf_body_len(input lpbf_kind_t k, input logic [15:0] len);
		// poll and reply carry no payload.
		return (k == K_POLL || k == K_REPLY) ? 16'h0000 : len;
	endfunction

	function automatic logic lpbf_req_ok(input lpbf_kind_t k, input logic [7:0] st);
		return (k != K_NONE) && !(k == K_REPLY && st == ST_RESERVED);
	endfunction

	function automatic lpbf_kind_t lpbf_decode(input logic [7:0] svc, input logic [7:0] sub);
		case ({svc[7:4], sub[7:4]})
			{SVC_SEQ, SUB_POLL}:  return K_POLL;
			{SVC_SEQ, SUB_REPLY}: return K_REPLY;
			{SVC_SEQ, SUB_DATA}:  return K_SEQ_DATA;
			{SVC_MUC, SUB_DATA}:  return K_MUC_DATA;
			{SVC_MSQ, SUB_DATA}:  return K_MSQ_DATA;
			default:              return K_NONE;
		endcase
	endfunction

	function automatic logic [7:0] lpbf_hdr_byte(input lpbf_kind_t k, input logic [2:0] idx,
			input logic [7:0] st, input logic [7:0] seq, input logic [15:0] sap,
			input logic [15:0] len);
		logic [3:0]  svc;
		logic [3:0]  sub;
		logic [15:0] ap;
		logic [15:0] ln;
		svc = SVC_SEQ;
		sub = SUB_DATA;
		ap  = sap;
		ln  = lpbf_body_len(k, len);
		case (k)
			K_POLL:     sub = SUB_POLL;
			K_REPLY:    sub = SUB_REPLY;
			K_SEQ_DATA: sub = SUB_DATA;
			K_MUC_DATA: begin
				svc = SVC_MUC;
				ap  = 16'h0000;
			end
			K_MSQ_DATA: svc = SVC_MSQ;
			default:    svc = 4'h0;
		endcase
		case (idx)
			OFS_SVC:    return {svc, 4'h0};
			OFS_SUB:    return {sub, 4'h0};
			OFS_STATUS: return lpbf_status(k, st);
			OFS_SEQ:    return seq;
			OFS_SAP_HI: return ap[15:8];
			OFS_SAP_LO: return ap[7:0];
			OFS_LEN_HI: return ln[15:8];
			default:    return ln[7:0];
		endcase
	endfunction
endpackage
`default_nettype wire
